// *** core/etsc_defs.vh ***
// Purpose: Constants for the external trigger switch control block.
// Assumes: 32-bit AXI4-Lite register bus, byte addresses.
// Notes:   Mode codes are two bits per trigger input.
`ifndef ETSC_DEFS_VH
`define ETSC_DEFS_VH

`define ETSC_ADDR_CTRL      8'h00
`define ETSC_ADDR_STATUS    8'h04
`define ETSC_ADDR_IRQ_STAT  8'h08
`define ETSC_ADDR_IRQ_MASK  8'h0C
`define ETSC_ADDR_CONFIG    8'h10
`define ETSC_ADDR_MEM_CMD   8'h14
`define ETSC_ADDR_MEM_STAT  8'h18

`define ETSC_MODE_OFF       2'h0
`define ETSC_MODE_EDGE      2'h1
`define ETSC_MODE_FAULT     2'h2
`define ETSC_MODE_INHIBIT   2'h3

`define ETSC_CTRL_PRI_LSB   0
`define ETSC_CTRL_SEC_LSB   2
`define ETSC_CTRL_RESET     32'h0000_0000
`define ETSC_CONFIG_RESET   32'h0000_0000

`define ETSC_CMD_SAVE_BIT   3
`define ETSC_SLOTS          5

`define ETSC_IRQ_PRI_EDGE   0
`define ETSC_IRQ_SEC_EDGE   1
`define ETSC_IRQ_SWITCH     2
`define ETSC_IRQ_BLOCKED    3
`define ETSC_IRQ_WIDTH      4

`define ETSC_RESP_OKAY      2'h0
`define ETSC_RESP_SLVERR    2'h2

`endif

// *** core/etsc_slots.v ***
// Purpose: Five setup storage slots with occupied flags.
// Assumes: Save and recall are one-cycle pulses with a valid slot index.
// Notes:   Recall of an empty slot leaves the settings untouched.
`timescale 1ns/1ns
`default_nettype none
module etsc_slots #(
    parameter WIDTH = 32,
    parameter SLOTS = 5
) (
    input  wire             clk,
    input  wire             rst_n,
    input  wire             save,
    input  wire             recall,
    input  wire [2:0]       slot,
    input  wire [WIDTH-1:0] cur_setup,
    output reg  [WIDTH-1:0] load_setup,
    output reg              load,
    output reg  [SLOTS-1:0] occupied
);
    reg [WIDTH-1:0] mem [0:SLOTS-1];
    integer i;

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (i = 0; i < SLOTS; i = i + 1)
                mem[i] <= {WIDTH{1'b0}};
            occupied   <= {SLOTS{1'b0}};
            load       <= 1'b0;
            load_setup <= {WIDTH{1'b0}};
        end else begin
            load <= 1'b0;
            if (save) begin
                mem[slot]      <= cur_setup;
                occupied[slot] <= 1'b1;
            end else if (recall && occupied[slot]) begin
                load_setup <= mem[slot];
                load       <= 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// *** core/etsc_sync.v ***
// Purpose: Three-stage input synchroniser with agreement filter and fall detect.
// Assumes: Asynchronous pin input, one clock.
// Notes:   Level changes once stages two and three agree.
`timescale 1ns/1ns
`default_nettype none
module etsc_sync (
    input  wire clk,
    input  wire rst_n,
    input  wire pin,
    output reg  level,
    output reg  fall
);
    reg s1;
    reg s2;
    reg s3;

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1    <= 1'b1;
            s2    <= 1'b1;
            s3    <= 1'b1;
            level <= 1'b1;
            fall  <= 1'b0;
        end else begin
            s1   <= pin;
            s2   <= s1;
            s3   <= s2;
            fall <= 1'b0;
            if (s2 == s3 && s3 != level) begin
                level <= s3;
                fall  <= ~s3;
            end
        end
    end
endmodule
`default_nettype wire

// *** core/etsc_top.v ***
// Purpose: External trigger changeover control with setup memory, AXI4-Lite.
// Assumes: Single clock; signal check and changeover path on the same clock.
// Notes:   Registers: control, status, irq status, irq mask, config, memory.
//
// Implementation choices: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/1ns
`default_nettype none
`include "etsc_defs.vh"
// Notes on behaviour
// - Two trigger inputs, primary and secondary, each with its own mode field.
// - An input in the off mode has no effect on any changeover decision.
// - In edge mode a high-to-low transition on the input requests a changeover.
// - In fault mode a lost signal or a low input requests a changeover.
// - In inhibit mode a low input blocks every changeover, fault or not.
// - The present level of each input is readable as a separate status bit.
// - A save to one of five slots stores the whole setup and marks it occupied.
// - A recall loads a slot only if it is occupied, and occupancy is readable.
module etsc_top (
    input  wire        clk,
    input  wire        arst_n,
    input  wire        primary_trigger_pin,
    input  wire        secondary_trigger_pin,
    input  wire        signal_loss,
    output reg         changeover_req,
    output reg         changeover_blocked,
    output reg         primary_trigger_level_indication,
    output reg         secondary_trigger_level_indication,
    output reg         irq,
    input  wire [7:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output reg         s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output reg         s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [7:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output reg         s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready
);
    reg        rst_m;
    reg        rst_n;
    reg [31:0] ctrl;
    reg [31:0] config_reg;
    reg [`ETSC_IRQ_WIDTH-1:0] irq_stat;
    reg [`ETSC_IRQ_WIDTH-1:0] irq_mask;
    reg        aw_held;
    reg [7:0]  aw_addr;
    reg        w_held;
    reg [31:0] w_data;
    reg [3:0]  w_strb;
    reg        slot_save;
    reg        slot_recall;
    reg [2:0]  slot_idx;

    wire       pri_level;
    wire       pri_fall;
    wire       sec_level;
    wire       sec_fall;
    wire [63:0] load_setup;
    wire        slot_load;
    wire [`ETSC_SLOTS-1:0] occupied;

    wire [1:0] pri_mode = ctrl[`ETSC_CTRL_PRI_LSB+1:`ETSC_CTRL_PRI_LSB];
    wire [1:0] sec_mode = ctrl[`ETSC_CTRL_SEC_LSB+1:`ETSC_CTRL_SEC_LSB];

    // Reset release through two flops
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rst_m <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_m <= 1'b1;
            rst_n <= rst_m;
        end
    end

    etsc_sync u_pri_sync (
        .clk   (clk),
        .rst_n (rst_n),
        .pin   (primary_trigger_pin),
        .level (pri_level),
        .fall  (pri_fall)
    );

    etsc_sync u_sec_sync (
        .clk   (clk),
        .rst_n (rst_n),
        .pin   (secondary_trigger_pin),
        .level (sec_level),
        .fall  (sec_fall)
    );

    etsc_slots #(
        .WIDTH (64),
        .SLOTS (`ETSC_SLOTS)
    ) u_slots (
        .clk        (clk),
        .rst_n      (rst_n),
        .save       (slot_save),
        .recall     (slot_recall),
        .slot       (slot_idx),
        .cur_setup  ({config_reg, ctrl}),
        .load_setup (load_setup),
        .load       (slot_load),
        .occupied   (occupied)
    );

    // Decision logic
    reg next_req;
    reg next_blocked;
    reg pri_inhibit;
    reg sec_inhibit;
    reg want;

    always @* begin
        pri_inhibit = (pri_mode == `ETSC_MODE_INHIBIT) && !pri_level;
        sec_inhibit = (sec_mode == `ETSC_MODE_INHIBIT) && !sec_level;
        want = 1'b0;
        if (pri_mode == `ETSC_MODE_EDGE && pri_fall)
            want = 1'b1;
        if (sec_mode == `ETSC_MODE_EDGE && sec_fall)
            want = 1'b1;
        if (pri_mode == `ETSC_MODE_FAULT && (signal_loss || !pri_level))
            want = 1'b1;
        if (sec_mode == `ETSC_MODE_FAULT && (signal_loss || !sec_level))
            want = 1'b1;
        // Off mode contributes nothing above
        next_blocked = pri_inhibit || sec_inhibit;
        next_req     = want && !next_blocked;
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            changeover_req                     <= 1'b0;
            changeover_blocked                 <= 1'b0;
            primary_trigger_level_indication   <= 1'b1;
            secondary_trigger_level_indication <= 1'b1;
        end else begin
            changeover_req                     <= next_req;
            changeover_blocked                 <= next_blocked;
            primary_trigger_level_indication   <= pri_level;
            secondary_trigger_level_indication <= sec_level;
        end
    end

    // Interrupt events; set wins over read clear
    wire [`ETSC_IRQ_WIDTH-1:0] events = {
        want && next_blocked,
        next_req,
        sec_fall,
        pri_fall
    };
    wire rd_take = s_axi_arvalid && s_axi_arready;
    wire rd_stat = rd_take && s_axi_araddr == `ETSC_ADDR_IRQ_STAT;
    wire wr_go   = aw_held && w_held && !s_axi_bvalid;

    function [31:0] strobe_merge;
        input [31:0] old;
        input [31:0] data;
        input [3:0]  strb;
        integer k;
        begin
            strobe_merge = old;
            for (k = 0; k < 4; k = k + 1)
                if (strb[k])
                    strobe_merge[k*8 +: 8] = data[k*8 +: 8];
        end
    endfunction

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_stat <= {`ETSC_IRQ_WIDTH{1'b0}};
            irq      <= 1'b0;
        end else begin
            irq_stat <= (rd_stat ? {`ETSC_IRQ_WIDTH{1'b0}} : irq_stat) | events;
            irq      <= |(irq_stat & irq_mask);
        end
    end

    // Write channel: address and data accepted in either order
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `ETSC_RESP_OKAY;
            aw_held       <= 1'b0;
            w_held        <= 1'b0;
            aw_addr       <= 8'h00;
            w_data        <= 32'h0000_0000;
            w_strb        <= 4'h0;
            ctrl          <= `ETSC_CTRL_RESET;
            config_reg    <= `ETSC_CONFIG_RESET;
            irq_mask      <= {`ETSC_IRQ_WIDTH{1'b0}};
            slot_save     <= 1'b0;
            slot_recall   <= 1'b0;
            slot_idx      <= 3'h0;
        end else begin
            slot_save     <= 1'b0;
            slot_recall   <= 1'b0;
            s_axi_awready <= !aw_held && !s_axi_awready && s_axi_awvalid;
            s_axi_wready  <= !w_held && !s_axi_wready && s_axi_wvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (slot_load) begin
                ctrl       <= load_setup[31:0];
                config_reg <= load_setup[63:32];
            end
            if (wr_go) begin
                aw_held      <= 1'b0;
                w_held       <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= `ETSC_RESP_OKAY;
                case (aw_addr)
                    `ETSC_ADDR_CTRL: begin
                        ctrl <= strobe_merge(ctrl, w_data, w_strb) & 32'h0000_000F;
                    end
                    `ETSC_ADDR_CONFIG: begin
                        config_reg <= strobe_merge(config_reg, w_data, w_strb);
                    end
                    `ETSC_ADDR_IRQ_MASK: begin
                        if (w_strb[0])
                            irq_mask <= w_data[`ETSC_IRQ_WIDTH-1:0];
                    end
                    `ETSC_ADDR_MEM_CMD: begin
                        // Bad slot number answers with an error, no action
                        if (w_strb[0] && w_data[2:0] < `ETSC_SLOTS) begin
                            slot_idx    <= w_data[2:0];
                            slot_save   <= w_data[`ETSC_CMD_SAVE_BIT];
                            slot_recall <= !w_data[`ETSC_CMD_SAVE_BIT];
                        end else begin
                            s_axi_bresp <= `ETSC_RESP_SLVERR;
                        end
                    end
                    `ETSC_ADDR_STATUS, `ETSC_ADDR_IRQ_STAT, `ETSC_ADDR_MEM_STAT: begin
                        s_axi_bresp <= `ETSC_RESP_OKAY;
                    end
                    default: begin
                        s_axi_bresp <= `ETSC_RESP_SLVERR;
                    end
                endcase
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Read channel
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= `ETSC_RESP_OKAY;
        end else begin
            s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
            if (rd_take) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp  <= `ETSC_RESP_OKAY;
                case (s_axi_araddr)
                    `ETSC_ADDR_CTRL:     s_axi_rdata <= ctrl;
                    `ETSC_ADDR_STATUS: begin
                        s_axi_rdata <= {28'h000_0000, changeover_blocked, changeover_req,
                                        sec_level, pri_level};
                    end
                    `ETSC_ADDR_IRQ_STAT: s_axi_rdata <= {28'h000_0000, irq_stat};
                    `ETSC_ADDR_IRQ_MASK: s_axi_rdata <= {28'h000_0000, irq_mask};
                    `ETSC_ADDR_CONFIG:   s_axi_rdata <= config_reg;
                    `ETSC_ADDR_MEM_CMD:  s_axi_rdata <= 32'h0000_0000;
                    `ETSC_ADDR_MEM_STAT: s_axi_rdata <= {27'h000_0000, occupied};
                    default: begin
                        s_axi_rdata <= 32'h0000_0000;
                        s_axi_rresp <= `ETSC_RESP_SLVERR;
                    end
                endcase
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

// *** tb/etsc_top_monitor.sv ***
// Purpose: Port-level checks for etsc_top.
// Assumes: One clock, asynchronous active-low reset.
// Notes:   Modes are internal, so requests are tied to levels and loss.
`timescale 1ns/1ns
`default_nettype none
module etsc_mon (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic primary_trigger_pin,
    input wire logic secondary_trigger_pin,
    input wire logic signal_loss,
    input wire logic changeover_req,
    input wire logic changeover_blocked,
    input wire logic primary_trigger_level_indication,
    input wire logic secondary_trigger_level_indication,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_rvalid
);
    default clocking dc @(posedge clk);
    endclocking
    default disable iff (!arst_n);
    wire pl = primary_trigger_level_indication;
    wire sl = secondary_trigger_level_indication;
    sequence quiet(pin);
        $stable(pin) [*6];
    endsequence
    sequence drop(pin, lvl);
        $fell(pin) ##0 lvl;
    endsequence
    property follows(pin, lvl);
        quiet(pin) |-> lvl == pin;
    endproperty
    property slow_sync(pin, lvl);
        drop(pin, lvl) |-> lvl [*2];
    endproperty
    pri_lvl_a: assert property (follows(primary_trigger_pin, pl))
        else $error("primary level does not follow pin");
    sec_lvl_a: assert property (follows(secondary_trigger_pin, sl))
        else $error("secondary level does not follow pin");
    pri_sync_a: assert property (slow_sync(primary_trigger_pin, pl))
        else $error("primary level moved before synchronising");
    sec_sync_a: assert property (slow_sync(secondary_trigger_pin, sl))
        else $error("secondary level moved before synchronising");
    blk_no_req_a: assert property (changeover_blocked |-> !changeover_req)
        else $error("request while blocked");
    blk_cause_a: assert property (changeover_blocked |-> !pl || !sl || !$past(pl) || !$past(sl))
        else $error("blocked with both inputs high");
    req_cause_a: assert property (changeover_req |-> signal_loss || $past(signal_loss)
        || !pl || !sl || !$past(pl) || !$past(sl))
        else $error("request without a cause");
    wr_resp_a: assert property ($rose(s_axi_awvalid) |-> ##[1:6] s_axi_bvalid)
        else $error("write response late");
    rd_resp_a: assert property ($rose(s_axi_arvalid) |-> ##[1:4] s_axi_rvalid)
        else $error("read response late");
    b_once_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write response repeated");
endmodule
bind etsc_top etsc_mon i_mon (.*);
`default_nettype wire

// *** tb/etsc_trig_src.sv ***
// Purpose: External contact equipment driving the two trigger inputs.
// Assumes: Bench commands levels; lag sets how slowly the contacts follow.
// Notes:   Pins move 3 ns after the edge, unrelated to sampling.
`timescale 1ns/1ns
`default_nettype none
module etsc_trig_src (
    input  wire logic       clk,
    input  wire logic       pri_cmd,
    input  wire logic       sec_cmd,
    input  wire logic [3:0] lag,
    output wire logic       pri_pin,
    output wire logic       sec_pin
);
    logic [15:0] pri_hist = 16'hffff;
    logic [15:0] sec_hist = 16'hffff;
    always @(posedge clk) begin
        pri_hist <= {pri_hist[14:0], pri_cmd};
        sec_hist <= {sec_hist[14:0], sec_cmd};
    end
    assign #3 pri_pin = pri_hist[lag];
    assign #3 sec_pin = sec_hist[lag];
endmodule
`default_nettype wire

// *** tb/external_trigger_switch_control_bench.sv ***
// Purpose: Register-level tests of etsc_top.
// Assumes: AXI4-Lite master tasks; partner model drives the pins.
// Notes:   Outputs are read at the edge, before the design updates.
`timescale 1ns/1ns
`default_nettype none
`include "etsc_defs.vh"
module external_trigger_switch_control_bench;
    localparam logic [1:0] OK = `ETSC_RESP_OKAY;
    localparam logic [1:0] ER = `ETSC_RESP_SLVERR;
    logic clk, arst_n, signal_loss, pri_cmd, sec_cmd, irq;
    logic primary_trigger_pin, secondary_trigger_pin, changeover_req, changeover_blocked;
    logic primary_trigger_level_indication, secondary_trigger_level_indication;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rmask;
    logic [3:0]  s_axi_wstrb, lag;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    int          n_mismatch, n_tests, n_req, base;
    etsc_top i_dut (.*);
    etsc_trig_src i_src (.clk(clk), .pri_cmd(pri_cmd), .sec_cmd(sec_cmd), .lag(lag),
        .pri_pin(primary_trigger_pin), .sec_pin(secondary_trigger_pin));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        if (changeover_req === 1'b1) n_req <= n_req + 1;
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
        n_tests++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge clk);
            if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
        chk(32'(s_axi_bresp), 32'(er), "bresp");
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er,
                      input string what);
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge clk);
            if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b0;
        chk(s_axi_rdata & rmask, exp, what);
        chk(32'(s_axi_rresp), 32'(er), "rresp");
    endtask
    // Waits long enough for the present lag plus synchroniser
    task automatic pins(input logic p, input logic s);
        @(posedge clk);
        pri_cmd <= p;
        sec_cmd <= s;
        repeat (12 + lag) @(posedge clk);
    endtask
    task automatic wrap_up;
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    initial begin
        #300000;
        n_mismatch++;
        wrap_up;
    end
    initial begin
        {arst_n, signal_loss, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 5'b0;
        {s_axi_arvalid, s_axi_rready, pri_cmd, sec_cmd} = 4'b0011;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, lag} = 52'h0;
        s_axi_wstrb = 4'hf;
        rmask = 32'hffff_ffff;
        n_mismatch = 0;
        n_tests = 0;
        n_req = 0;
        repeat (20) @(posedge clk);
        arst_n <= 1'b1;
        repeat (3) @(posedge clk);
        rd(`ETSC_ADDR_CTRL, 32'h0000_0000, OK, "ctrl");
        rd(`ETSC_ADDR_STATUS, 32'h0000_0003, OK, "status");
        rd(`ETSC_ADDR_MEM_STAT, 32'h0000_0000, OK, "occupied");
        rd(8'h40, 32'h0000_0000, ER, "unmapped");
        // Both inputs off
        pins(1'b0, 1'b0);
        rd(`ETSC_ADDR_STATUS, 32'h0000_0000, OK, "status");
        pins(1'b1, 1'b1);
        chk(n_req, 0, "off requests");
        rmask = 32'h0000_0004;
        rd(`ETSC_ADDR_IRQ_STAT, 32'h0000_0000, OK, "off irq");
        rmask = 32'hffff_ffff;
        // Edge mode, slow far side
        wr(`ETSC_ADDR_IRQ_MASK, 32'h0000_000f, OK);
        wr(`ETSC_ADDR_CTRL, 32'h0000_0005, OK);
        base = n_req;
        lag <= 4'h9;
        pins(1'b0, 1'b1);
        chk(n_req - base, 1, "edge requests");
        chk(32'(irq), 1, "irq");
        rd(`ETSC_ADDR_IRQ_STAT, 32'h0000_0005, OK, "irq_stat");
        rd(`ETSC_ADDR_IRQ_STAT, 32'h0000_0000, OK, "irq_stat");
        chk(32'(irq), 0, "irq");
        pins(1'b1, 1'b1);
        chk(n_req - base, 1, "rise requests");
        wr(`ETSC_ADDR_IRQ_MASK, 32'h0000_0001, OK);
        pins(1'b1, 1'b0);
        chk(n_req - base, 2, "sec requests");
        chk(32'(irq), 0, "masked irq");
        rd(`ETSC_ADDR_IRQ_STAT, 32'h0000_0006, OK, "irq_stat");
        pins(1'b1, 1'b1);
        lag <= 4'h0;
        // Fault mode on primary
        wr(`ETSC_ADDR_CTRL, 32'h0000_0002, OK);
        signal_loss <= 1'b1;
        repeat (4) @(posedge clk);
        chk(32'(changeover_req), 1, "loss req");
        signal_loss <= 1'b0;
        repeat (4) @(posedge clk);
        chk(32'(changeover_req), 0, "no req");
        pins(1'b0, 1'b1);
        chk(32'(changeover_req), 1, "low req");
        // Inhibit on secondary
        wr(`ETSC_ADDR_CTRL, 32'h0000_000e, OK);
        pins(1'b1, 1'b0);
        signal_loss <= 1'b1;
        repeat (4) @(posedge clk);
        chk(32'(changeover_req), 0, "inhibited");
        chk(32'(changeover_blocked), 1, "blocked");
        chk(32'(primary_trigger_level_indication), 1, "pri level");
        chk(32'(secondary_trigger_level_indication), 0, "sec level");
        rd(`ETSC_ADDR_STATUS, 32'h0000_0009, OK, "status");
        rmask = 32'h0000_0008;
        rd(`ETSC_ADDR_IRQ_STAT, 32'h0000_0008, OK, "blocked irq");
        rmask = 32'hffff_ffff;
        pins(1'b1, 1'b1);
        chk(32'(changeover_req), 1, "released");
        signal_loss <= 1'b0;
        wr(`ETSC_ADDR_STATUS, 32'h0000_000f, OK);
        // Setup slots
        wr(`ETSC_ADDR_CONFIG, 32'haaaa_5555, OK);
        wr(`ETSC_ADDR_MEM_CMD, 32'h0000_0002, OK);
        rd(`ETSC_ADDR_CONFIG, 32'haaaa_5555, OK, "empty recall");
        for (int i = 0; i < 5; i++) begin
            wr(`ETSC_ADDR_CONFIG, 32'h0000_0100 + i, OK);
            wr(`ETSC_ADDR_CTRL, 32'(i), OK);
            wr(`ETSC_ADDR_MEM_CMD, 32'h0000_0008 + i, OK);
        end
        wr(`ETSC_ADDR_MEM_CMD, 32'h0000_000d, ER);
        rd(`ETSC_ADDR_MEM_STAT, 32'h0000_001f, OK, "occupied");
        wr(`ETSC_ADDR_CONFIG, 32'h0000_0000, OK);
        for (int i = 4; i >= 0; i--) begin
            wr(`ETSC_ADDR_MEM_CMD, 32'(i), OK);
            rd(`ETSC_ADDR_CONFIG, 32'h0000_0100 + i, OK, "config");
            rd(`ETSC_ADDR_CTRL, 32'(i), OK, "ctrl");
        end
        // Reset in mid-run must empty the slots and the setup
        arst_n <= 1'b0;
        repeat (2) @(posedge clk);
        chk(32'(primary_trigger_level_indication), 1, "reset pri level");
        chk(32'(secondary_trigger_level_indication), 1, "reset sec level");
        arst_n <= 1'b1;
        repeat (3) @(posedge clk);
        rd(`ETSC_ADDR_MEM_STAT, 32'h0000_0000, OK, "reset slots");
        rd(`ETSC_ADDR_CONFIG, 32'h0000_0000, OK, "reset config");
        wrap_up;
    end
endmodule
`default_nettype wire
